// File: verilog/gbx_pkg.sv
// Purpose: constants for the three-bank pin block with interrupt sense control
// Assumes: APB word addressing, byte address is four times the register index
// Notes: pin vectors hold bank A in bits 7:0, bank B in 15:8, bank C in 23:16
`default_nettype none
package gbx_pkg;
	localparam int PIN_W = 8;
	localparam int BANKS = 3;
	localparam int PINS = PIN_W * BANKS;
	localparam int BANK_A = 0;
	localparam int BANK_B = 1;
	localparam int BANK_C = 2;
	localparam int IDX_W = 4;
	localparam int IDX_LSB = 2;
	// register indices
	localparam logic [IDX_W-1:0] IDX_C_DATA = 4'h0;
	localparam logic [IDX_W-1:0] IDX_C_DIR = 4'h1;
	localparam logic [IDX_W-1:0] IDX_C_OPT = 4'h2;
	localparam logic [IDX_W-1:0] IDX_B_DATA = 4'h4;
	localparam logic [IDX_W-1:0] IDX_B_DIR = 4'h5;
	localparam logic [IDX_W-1:0] IDX_B_OPT = 4'h6;
	localparam logic [IDX_W-1:0] IDX_A_DATA = 4'h8;
	localparam logic [IDX_W-1:0] IDX_A_DIR = 4'h9;
	localparam logic [IDX_W-1:0] IDX_A_OPT = 4'ha;
	localparam logic [IDX_W-1:0] IDX_SENSE_CLK = 4'hc;
	localparam logic [IDX_W-1:0] IDX_SPI_CTRL = 4'hd;
	localparam logic [IDX_W-1:0] IDX_SRC_CFG = 4'he;
	localparam logic [IDX_W-1:0] IDX_DATA [BANKS] = '{IDX_A_DATA, IDX_B_DATA, IDX_C_DATA};
	localparam logic [IDX_W-1:0] IDX_DIR [BANKS] = '{IDX_A_DIR, IDX_B_DIR, IDX_C_DIR};
	localparam logic [IDX_W-1:0] IDX_OPT [BANKS] = '{IDX_A_OPT, IDX_B_OPT, IDX_C_OPT};
	// reset values
	localparam logic [PIN_W-1:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] RESET_SPI = 4'h0;
	// sense and clock control fields
	localparam int G1_SENSE_HI = 7;
	localparam int G1_SENSE_LO = 6;
	localparam int CLK_OUT_BIT = 5;
	localparam int G0_SENSE_HI = 4;
	localparam int G0_SENSE_LO = 3;
	localparam int DIV_HI = 2;
	localparam int DIV_LO = 1;
	localparam int SLOW_BIT = 0;
	// spi control fields
	localparam int SPI_W = 4;
	localparam int MOD_BIT = 3;
	localparam int SOD_BIT = 2;
	localparam int SSM_BIT = 1;
	localparam int SSI_BIT = 0;
	localparam int SRC_SEL_BIT = 0;
	// special pins, absolute position in the pin vector
	localparam int PIN_CLK_OUT = BANK_C * PIN_W + 2;
	localparam int PIN_SS = BANK_B * PIN_W + 7;
	localparam int PIN_MOSI = BANK_B * PIN_W + 4;
	localparam int PIN_MISO = BANK_B * PIN_W + 5;
	localparam logic [PINS-1:0] TRUE_OD_PINS = 24'h000050;
	localparam logic [PINS-1:0] OPT_PINS = 24'hffffff;
	typedef enum logic [1:0] {
		SENSE_FALL_LOW = 2'h0,
		SENSE_RISE = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_BOTH = 2'h3
	} gbx_sense_t;
endpackage : gbx_pkg
`default_nettype wire

// File: verilog/gbx_bank_irq.sv
// Purpose: three 8-bit pin banks with data, direction and option registers,
//          two external interrupt groups with selectable sense, clock out
// Assumes: pins and peripheral signals synchronous inputs, single 10 MHz clock
// Notes: APB slave answers with no wait state; read data latched in setup phase
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1 - direction bit per pin, set means output
// RL2 - option picks floating/pull-up or open-drain/push-pull
// RL3 - true open-drain pins: no pull-up, never high
// RL4 - pins without option bit use direction alone
// RL5 - data writes always update the latch
// RL6 - data read: latch if output, pin if input
// RL7 - all registers reset to zero
// RL8 - requests only while cpu mask is clear
// RL9 - low power leaves banks untouched, events wake
// RL10 - four sense modes per group, codes 00-11
// RL11 - bits 7:6 set group 1 sense
// RL12 - bits 4:3 set group 0 sense
// RL13 - sense fields writable only while masked
// RL14 - source option steers bank C to a group
// RL15 - bit 5 drives cpu clock on C2
// RL16 - spi select internal, output pins disableable
// RL17 - pending cleared by vector fetch or rewrite
// RL18 - group pin levels are ANDed together
// RL19 - alternate function overrides pin programming
// RL20 - inputs synchronised, edges by sample compare
module gbx_bank_irq #(
	parameter int ADDR_W = 8,
	parameter logic [gbx_pkg::PINS-1:0] OPT_PRESENT = gbx_pkg::OPT_PINS,
	parameter logic [gbx_pkg::PINS-1:0] TRUE_OD = gbx_pkg::TRUE_OD_PINS
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// pins
	input wire logic [gbx_pkg::PINS-1:0] pin_in,
	output logic [gbx_pkg::PINS-1:0] pin_out,
	output logic [gbx_pkg::PINS-1:0] pin_oe_out,
	output logic [gbx_pkg::PINS-1:0] pin_pullup_out,
	// peripheral alternate functions
	input wire logic [gbx_pkg::PINS-1:0] alt_en_in,
	input wire logic [gbx_pkg::PINS-1:0] alt_out_in,
	input wire logic [gbx_pkg::PINS-1:0] alt_od_in,
	output logic [gbx_pkg::PINS-1:0] pin_level_out,
	output logic spi_ss_level_out,
	// cpu side
	input wire logic cpu_irq_mask_in,
	input wire logic vec0_fetch_in,
	input wire logic vec1_fetch_in,
	output logic ext_irq_group0_out,
	output logic ext_irq_group1_out,
	output logic wake_out,
	output logic slow_mode_select_out,
	output logic [1:0] slow_divider_out
);
	localparam int P = gbx_pkg::PINS;
	localparam int W = gbx_pkg::PIN_W;

	logic [P-1:0] data_q, data_d, dir_q, dir_d, opt_q, opt_d;
	logic [W-1:0] ctrl_q, ctrl_d;
	logic [gbx_pkg::SPI_W-1:0] spi_q, spi_d;
	logic src_sel_q, src_sel_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic [P-1:0] sync1_q, sync2_q;
	logic lvl0_q, lvl1_q, pend0_q, pend1_q;
	logic lvl0_d, lvl1_d, pend0_d, pend1_d;
	logic [P-1:0] opt_eff, push_pull, irq_src, rd_level;
	logic [gbx_pkg::IDX_W-1:0] idx;
	logic wr, setup, sense_wr;
	logic ev0, ev1;

	assign idx = paddr_in[gbx_pkg::IDX_LSB +: gbx_pkg::IDX_W];
	assign wr = psel_in & penable_in & pwrite_in;
	assign setup = psel_in & ~penable_in;
	assign pready_out = 1'b1;
	assign prdata_out = rdata_q;
	assign pslverr_out = err_q & psel_in & penable_in;
	// sense fields accept writes only while the cpu masks interrupts
	assign sense_wr = wr & (idx == gbx_pkg::IDX_SENSE_CLK) & cpu_irq_mask_in; // RL13

	// per-pin configuration and pad drive
	genvar gi;
	generate
		for (gi = 0; gi < P; gi++) begin : g_pin
			logic alt, clk_pin, od, val;
			// option bit absent: input floating, output push-pull
			assign opt_eff[gi] = OPT_PRESENT[gi] & opt_q[gi]; // RL4
			assign push_pull[gi] = OPT_PRESENT[gi] ? opt_q[gi] : 1'b1; // RL4
			assign irq_src[gi] = ~dir_q[gi] & opt_eff[gi]; // RL2
			assign clk_pin = (gi == gbx_pkg::PIN_CLK_OUT) ? ctrl_q[gbx_pkg::CLK_OUT_BIT] : 1'b0; // RL15
			if (gi == gbx_pkg::PIN_MOSI) begin : g_mosi
				assign alt = alt_en_in[gi] & ~spi_q[gbx_pkg::MOD_BIT]; // RL16
			end else if (gi == gbx_pkg::PIN_MISO) begin : g_miso
				assign alt = alt_en_in[gi] & ~spi_q[gbx_pkg::SOD_BIT]; // RL16
			end else begin : g_plain
				assign alt = alt_en_in[gi];
			end
			// alternate output takes priority over the latch
			assign val = clk_pin ? clk_in : (alt ? alt_out_in[gi] : data_q[gi]); // RL19
			assign od = TRUE_OD[gi] | (~clk_pin & (alt ? alt_od_in[gi] : ~push_pull[gi])); // RL2 RL3
			assign pin_out[gi] = val;
			assign pin_oe_out[gi] = (clk_pin | alt | dir_q[gi]) & (~od | ~val); // RL1 RL3 RL19
			assign pin_pullup_out[gi] = ~dir_q[gi] & ~alt & opt_eff[gi] & ~TRUE_OD[gi]; // RL2 RL3
			assign rd_level[gi] = dir_q[gi] ? data_q[gi] : sync2_q[gi]; // RL6
		end
	endgenerate
	assign pin_level_out = rd_level;
	assign spi_ss_level_out = spi_q[gbx_pkg::SSM_BIT] ? spi_q[gbx_pkg::SSI_BIT] : sync2_q[gbx_pkg::PIN_SS]; // RL16
	assign slow_mode_select_out = ctrl_q[gbx_pkg::SLOW_BIT];
	assign slow_divider_out = ctrl_q[gbx_pkg::DIV_HI:gbx_pkg::DIV_LO];
	assign ext_irq_group0_out = pend0_q;
	assign ext_irq_group1_out = pend1_q;
	// banks ignore low power; a pending event is the wake source
	assign wake_out = pend0_q | pend1_q; // RL9

	// register writes and read mux
	always_comb begin
		data_d = data_q;
		dir_d = dir_q;
		opt_d = opt_q;
		ctrl_d = ctrl_q;
		spi_d = spi_q;
		src_sel_d = src_sel_q;
		rdata_d = rdata_q;
		err_d = err_q;
		if (setup) begin
			rdata_d = '0;
			err_d = 1'b1;
		end
		for (int b = 0; b < gbx_pkg::BANKS; b++) begin
			if (idx == gbx_pkg::IDX_DATA[b]) begin
				if (wr)
					data_d[b*W +: W] = pwdata_in[W-1:0]; // RL5
				if (setup) begin
					rdata_d[W-1:0] = rd_level[b*W +: W]; // RL6
					err_d = 1'b0;
				end
			end
			if (idx == gbx_pkg::IDX_DIR[b]) begin
				if (wr)
					dir_d[b*W +: W] = pwdata_in[W-1:0]; // RL1
				if (setup) begin
					rdata_d[W-1:0] = dir_q[b*W +: W];
					err_d = 1'b0;
				end
			end
			if (idx == gbx_pkg::IDX_OPT[b]) begin
				if (wr)
					opt_d[b*W +: W] = pwdata_in[W-1:0]; // RL2
				if (setup) begin
					rdata_d[W-1:0] = opt_q[b*W +: W];
					err_d = 1'b0;
				end
			end
		end
		if (idx == gbx_pkg::IDX_SENSE_CLK) begin
			if (wr) begin
				ctrl_d[gbx_pkg::CLK_OUT_BIT] = pwdata_in[gbx_pkg::CLK_OUT_BIT]; // RL15
				ctrl_d[gbx_pkg::DIV_HI:gbx_pkg::SLOW_BIT] = pwdata_in[gbx_pkg::DIV_HI:gbx_pkg::SLOW_BIT];
			end
			if (sense_wr) begin
				ctrl_d[gbx_pkg::G1_SENSE_HI:gbx_pkg::G1_SENSE_LO] =
					pwdata_in[gbx_pkg::G1_SENSE_HI:gbx_pkg::G1_SENSE_LO]; // RL11 RL13
				ctrl_d[gbx_pkg::G0_SENSE_HI:gbx_pkg::G0_SENSE_LO] =
					pwdata_in[gbx_pkg::G0_SENSE_HI:gbx_pkg::G0_SENSE_LO]; // RL12 RL13
			end
			if (setup) begin
				rdata_d[W-1:0] = ctrl_q;
				err_d = 1'b0;
			end
		end
		if (idx == gbx_pkg::IDX_SPI_CTRL) begin
			if (wr)
				spi_d = pwdata_in[gbx_pkg::SPI_W-1:0]; // RL16
			if (setup) begin
				rdata_d[gbx_pkg::SPI_W-1:0] = spi_q;
				err_d = 1'b0;
			end
		end
		if (idx == gbx_pkg::IDX_SRC_CFG) begin
			if (wr)
				src_sel_d = pwdata_in[gbx_pkg::SRC_SEL_BIT]; // RL14
			if (setup) begin
				rdata_d[gbx_pkg::SRC_SEL_BIT] = src_sel_q;
				err_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			data_q <= {gbx_pkg::BANKS{gbx_pkg::RESET_BYTE}}; // RL7
			dir_q <= {gbx_pkg::BANKS{gbx_pkg::RESET_BYTE}}; // RL7
			opt_q <= {gbx_pkg::BANKS{gbx_pkg::RESET_BYTE}}; // RL7
			ctrl_q <= gbx_pkg::RESET_BYTE; // RL7
			spi_q <= gbx_pkg::RESET_SPI;
			src_sel_q <= 1'b0;
			rdata_q <= '0;
			err_q <= 1'b0;
		end else begin
			data_q <= data_d;
			dir_q <= dir_d;
			opt_q <= opt_d;
			ctrl_q <= ctrl_d;
			spi_q <= spi_d;
			src_sel_q <= src_sel_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// external interrupt groups
	function automatic logic sense_hit(input logic [1:0] mode, input logic prev, input logic cur);
		logic rise, fall;
		rise = ~prev & cur;
		fall = prev & ~cur;
		unique case (gbx_pkg::gbx_sense_t'(mode)) // RL10
			gbx_pkg::SENSE_FALL_LOW: sense_hit = ~cur;
			gbx_pkg::SENSE_RISE: sense_hit = rise;
			gbx_pkg::SENSE_FALL: sense_hit = fall;
			gbx_pkg::SENSE_BOTH: sense_hit = rise | fall;
		endcase
	endfunction : sense_hit

	always_comb begin
		logic a_and, b_and, c_and;
		a_and = &(sync2_q[gbx_pkg::BANK_A*W +: W] | ~irq_src[gbx_pkg::BANK_A*W +: W]); // RL18
		b_and = &(sync2_q[gbx_pkg::BANK_B*W +: W] | ~irq_src[gbx_pkg::BANK_B*W +: W]); // RL18
		c_and = &(sync2_q[gbx_pkg::BANK_C*W +: W] | ~irq_src[gbx_pkg::BANK_C*W +: W]); // RL18
		// bank C joins group 0 when selected, otherwise group 1
		lvl0_d = a_and & (src_sel_q ? c_and : 1'b1); // RL14
		lvl1_d = b_and & (src_sel_q ? 1'b1 : c_and); // RL14
		ev0 = sense_hit(ctrl_q[gbx_pkg::G0_SENSE_HI:gbx_pkg::G0_SENSE_LO], lvl0_q, lvl0_d); // RL12 RL20
		ev1 = sense_hit(ctrl_q[gbx_pkg::G1_SENSE_HI:gbx_pkg::G1_SENSE_LO], lvl1_q, lvl1_d); // RL11 RL20
		// an unmasked new event wins over a vector fetch clear in the same cycle
		pend0_d = (ev0 & ~cpu_irq_mask_in) | (pend0_q & ~vec0_fetch_in & ~sense_wr); // RL8 RL17
		pend1_d = (ev1 & ~cpu_irq_mask_in) | (pend1_q & ~vec1_fetch_in & ~sense_wr); // RL8 RL17
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			lvl0_q <= 1'b1;
			lvl1_q <= 1'b1;
			pend0_q <= 1'b0;
			pend1_q <= 1'b0;
		end else begin
			sync1_q <= pin_in; // RL20
			sync2_q <= sync1_q; // RL20
			lvl0_q <= lvl0_d;
			lvl1_q <= lvl1_d;
			pend0_q <= pend0_d;
			pend1_q <= pend1_d;
		end
	end

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_dir_write;
		wr && idx == gbx_pkg::IDX_A_DIR;
	endsequence
	property p_dir_write;
		s_dir_write |=> dir_q[7:0] == $past(pwdata_in[7:0]);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write not stored"); // RL1

	property p_latch_write_input;
		(wr && idx == gbx_pkg::IDX_A_DATA && dir_q[7:0] == 8'h00) |=> data_q[7:0] == $past(pwdata_in[7:0]);
	endproperty
	a_latch_write_input: assert property (p_latch_write_input) else $error("latch ignored write in input mode"); // RL5

	property p_data_read;
		(setup && idx == gbx_pkg::IDX_A_DATA) ##1 (psel_in && penable_in && !pwrite_in)
			|-> prdata_out[7:0] == $past(rd_level[7:0]) && $past(rd_level[7:0]) ==
			(($past(dir_q[7:0]) & $past(data_q[7:0])) | (~$past(dir_q[7:0]) & $past(sync2_q[7:0])));
	endproperty
	a_data_read: assert property (p_data_read) else $error("data read returned wrong source"); // RL6

	property p_sense_locked;
		(wr && idx == gbx_pkg::IDX_SENSE_CLK && !cpu_irq_mask_in)
			|=> $stable(ctrl_q[gbx_pkg::G1_SENSE_HI:gbx_pkg::G1_SENSE_LO])
			&& $stable(ctrl_q[gbx_pkg::G0_SENSE_HI:gbx_pkg::G0_SENSE_LO]);
	endproperty
	a_sense_locked: assert property (p_sense_locked) else $error("sense field changed while unmasked"); // RL13

	property p_req_needs_unmask;
		$rose(pend0_q) |-> !$past(cpu_irq_mask_in) && $past(ev0);
	endproperty
	a_req_needs_unmask: assert property (p_req_needs_unmask) else $error("request raised while masked"); // RL8

	property p_fetch_clears;
		(pend1_q && vec1_fetch_in && !(ev1 && !cpu_irq_mask_in)) |=> !pend1_q;
	endproperty
	a_fetch_clears: assert property (p_fetch_clears) else $error("vector fetch left request pending"); // RL17

	property p_true_od_low_only;
		(pin_oe_out[4] |-> !pin_out[4]) and (pin_oe_out[6] |-> !pin_out[6]) and !pin_pullup_out[4] and !pin_pullup_out[6];
	endproperty
	a_true_od_low_only: assert property (p_true_od_low_only) else $error("true open-drain pin drove high"); // RL3

	property p_clock_out;
		ctrl_q[gbx_pkg::CLK_OUT_BIT] |-> pin_oe_out[gbx_pkg::PIN_CLK_OUT];
	endproperty
	a_clock_out: assert property (p_clock_out) else $error("clock output not driven"); // RL15

	sequence s_rise0;
		!lvl0_q && lvl0_d && ctrl_q[gbx_pkg::G0_SENSE_HI:gbx_pkg::G0_SENSE_LO] == gbx_pkg::SENSE_RISE
			&& !cpu_irq_mask_in;
	endsequence
	property p_rise_event;
		s_rise0 |=> pend0_q;
	endproperty
	a_rise_event: assert property (p_rise_event) else $error("rising edge missed in group 0"); // RL10

	property p_req_needs_unmask1;
		$rose(pend1_q) |-> !$past(cpu_irq_mask_in) && $past(ev1);
	endproperty
	a_req_needs_unmask1: assert property (p_req_needs_unmask1) else $error("group 1 request raised while masked"); // RL8

	property p_sense_write_clears;
		(sense_wr && !(ev0 && !cpu_irq_mask_in)) |=> !pend0_q;
	endproperty
	a_sense_write_clears: assert property (p_sense_write_clears) else $error("sense write left request pending"); // RL17

	property p_pullup_input_only;
		(pin_pullup_out & dir_q) == '0;
	endproperty
	a_pullup_input_only: assert property (p_pullup_input_only) else $error("pull-up on an output pin"); // RL2

	property p_push_pull_drive;
		(dir_q[0] && opt_q[0] && !alt_en_in[0]) |-> pin_oe_out[0] && pin_out[0] == data_q[0];
	endproperty
	a_push_pull_drive: assert property (p_push_pull_drive) else $error("push-pull pin not driving latch"); // RL2

	property p_open_drain_release;
		(dir_q[0] && !opt_q[0] && !alt_en_in[0] && data_q[0]) |-> !pin_oe_out[0];
	endproperty
	a_open_drain_release: assert property (p_open_drain_release) else $error("open-drain pin drove high"); // RL2

	property p_low_source_masks;
		(irq_src[0] && !sync2_q[0]) |-> !lvl0_d;
	endproperty
	a_low_source_masks: assert property (p_low_source_masks) else $error("low source pin did not mask group"); // RL18

	property p_bank_c_steer;
		(src_sel_q && irq_src[gbx_pkg::BANK_C*W] && !sync2_q[gbx_pkg::BANK_C*W]) |-> !lvl0_d;
	endproperty
	a_bank_c_steer: assert property (p_bank_c_steer) else $error("bank C source not in group 0"); // RL14

	sequence s_fall1;
		lvl1_q && !lvl1_d && ctrl_q[gbx_pkg::G1_SENSE_HI:gbx_pkg::G1_SENSE_LO] == gbx_pkg::SENSE_FALL
			&& !cpu_irq_mask_in;
	endsequence
	property p_fall_event;
		s_fall1 |=> pend1_q;
	endproperty
	a_fall_event: assert property (p_fall_event) else $error("falling edge missed in group 1"); // RL10 RL11

	sequence s_low1;
		!lvl1_d && ctrl_q[gbx_pkg::G1_SENSE_HI:gbx_pkg::G1_SENSE_LO] == gbx_pkg::SENSE_FALL_LOW
			&& !cpu_irq_mask_in;
	endsequence
	property p_low_level;
		s_low1 |=> pend1_q;
	endproperty
	a_low_level: assert property (p_low_level) else $error("low level missed in group 1"); // RL10

	property p_both_event;
		(lvl0_q != lvl0_d && ctrl_q[gbx_pkg::G0_SENSE_HI:gbx_pkg::G0_SENSE_LO] == gbx_pkg::SENSE_BOTH
			&& !cpu_irq_mask_in) |=> pend0_q;
	endproperty
	a_both_event: assert property (p_both_event) else $error("edge missed in group 0 both mode"); // RL10 RL12
endmodule : gbx_bank_irq
`default_nettype wire

// File: test/gbx_pad_model.sv
// Purpose: pad model for the three pin banks
// Assumes: the bench enables an external driver per pin
// Notes: a pad nobody drives and without pull-up toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module gbx_pad_model (
	// clock
	input wire logic clk_in,
	// block side
	input wire logic [gbx_pkg::PINS-1:0] pad_drive_in,
	input wire logic [gbx_pkg::PINS-1:0] pad_oe_in,
	input wire logic [gbx_pkg::PINS-1:0] pad_pullup_in,
	// bench side
	input wire logic [gbx_pkg::PINS-1:0] ext_en_in,
	input wire logic [gbx_pkg::PINS-1:0] ext_val_in,
	output logic [gbx_pkg::PINS-1:0] pad_level_out
);
	logic [gbx_pkg::PINS-1:0] float_q = '0;
	always @(posedge clk_in) begin
		float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < gbx_pkg::PINS; i++) begin
			if (pad_oe_in[i]) pad_level_out[i] = pad_drive_in[i];
			else if (ext_en_in[i]) pad_level_out[i] = ext_val_in[i];
			else if (pad_pullup_in[i]) pad_level_out[i] = 1'b1;
			else pad_level_out[i] = float_q[i];
		end
	end
endmodule : gbx_pad_model
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for the pin bank block
// Assumes: pads resolved by the pad model, registers over apb
// Notes: bank A bits 7:0, bank B 15:8, bank C 23:16
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_in = 0, reset_n_in = 0, psel = 0, penable = 0, pwrite = 0, mask = 1, v0 = 0, v1 = 0;
	logic pready, slverr, i0, i1, wake, ss, sm, err;
	logic [1:0] sd;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [23:0] pin_in, pout, poe, ppu, plv, ext_val = 0, aen = 0, aout = 0, aod = 0;
	logic [23:0] ext_en = 24'hffffff;
	int n_mismatch = 0, n_compared = 0;
	always #50 clk_in = ~clk_in;
	gbx_bank_irq i_gbx_bank_irq (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(slverr), .pin_in(pin_in),
		.pin_out(pout), .pin_oe_out(poe), .pin_pullup_out(ppu), .alt_en_in(aen),
		.alt_out_in(aout), .alt_od_in(aod), .pin_level_out(plv), .spi_ss_level_out(ss),
		.cpu_irq_mask_in(mask), .vec0_fetch_in(v0), .vec1_fetch_in(v1), .ext_irq_group0_out(i0),
		.ext_irq_group1_out(i1), .wake_out(wake), .slow_mode_select_out(sm), .slow_divider_out(sd));
	gbx_pad_model i_gbx_pad_model (.clk_in(clk_in), .pad_drive_in(pout), .pad_oe_in(poe),
		.pad_pullup_in(ppu), .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(pin_in));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	// one apb transfer, setup on the next edge, held until pready
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
		r = prdata;
		err = slverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, {24'h0, d});
	endtask : wr
	task automatic rc(input string nm, input logic [3:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 32'h0);
		chk(nm, {24'h0, e}, r);
	endtask : rc
	// drive mask and pads, then let sync and pending settle
	task automatic drv(input logic m, input logic [23:0] v);
		@(posedge clk_in);
		mask <= m;
		ext_val <= v;
		repeat (5) @(posedge clk_in);
	endtask : drv
	initial begin
		repeat (60000) @(posedge clk_in);
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [23:0] v, o;
		logic e;
		repeat (3) @(posedge clk_in);
		reset_n_in <= 1'b1;
		for (int b = 0; b < 3; b++) begin
			rc("data_rst", gbx_pkg::IDX_DATA[b], 8'h00);
			rc("dir_rst", gbx_pkg::IDX_DIR[b], 8'h00);
			rc("opt_rst", gbx_pkg::IDX_OPT[b], 8'h00);
		end
		rc("ctrl_rst", gbx_pkg::IDX_SENSE_CLK, 8'h00);
		chk("oe_rst", 32'h0, {8'h0, poe | ppu});
		$display("test reset done");
		for (int b = 0; b < 3; b++) begin
			wr(gbx_pkg::IDX_DIR[b], 8'h5a);
			rc("dir", gbx_pkg::IDX_DIR[b], 8'h5a);
			chk("oe_dir", 32'h5a, {24'h0, poe[b*8+:8]});
			wr(gbx_pkg::IDX_DIR[b], 8'h00);
		end
		ext_val <= 24'h00003c;
		wr(gbx_pkg::IDX_A_DATA, 8'hff);
		rc("a_in", gbx_pkg::IDX_A_DATA, 8'h3c);
		ext_en <= 24'hffff00;
		wr(gbx_pkg::IDX_A_OPT, 8'hff);
		wr(gbx_pkg::IDX_A_DIR, 8'hff);
		rc("a_out", gbx_pkg::IDX_A_DATA, 8'hff);
		@(negedge clk_in);
		chk("oe_pp", 32'haf, {24'h0, poe[7:0]});
		chk("drv_pp", 32'haf, {24'h0, poe[7:0] & pout[7:0]});
		wr(gbx_pkg::IDX_A_OPT, 8'h00);
		@(negedge clk_in);
		chk("oe_od", 32'h0, {24'h0, poe[7:0]});
		wr(gbx_pkg::IDX_A_DATA, 8'h00);
		@(negedge clk_in);
		chk("oe_low", 32'hff, {24'h0, poe[7:0]});
		chk("level", 32'h0, {24'h0, plv[7:0]});
		wr(gbx_pkg::IDX_A_DIR, 8'h00);
		wr(gbx_pkg::IDX_A_OPT, 8'hff);
		@(negedge clk_in);
		chk("pullup", 32'haf, {24'h0, ppu[7:0]});
		xfer(1'b0, 4'h3, 32'h0);
		ext_en <= 24'hffffff;
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, r);
		@(posedge clk_in);
		aen <= 24'h010000;
		aout <= 24'h010000;
		@(negedge clk_in);
		chk("alt", 32'h3, {30'h0, poe[16], pout[16]});
		@(posedge clk_in);
		aen <= 24'h0;
		$display("test port modes done");
		drv(1'b0, 24'h0);
		wr(gbx_pkg::IDX_SENSE_CLK, 8'hff);
		rc("ctrl_unmasked", gbx_pkg::IDX_SENSE_CLK, 8'h27);
		chk("slow", 32'h7, {29'h0, sm, sd});
		chk("clk_out", 32'h1, {31'h0, poe[gbx_pkg::PIN_CLK_OUT]});
		drv(1'b1, 24'h0);
		wr(gbx_pkg::IDX_SENSE_CLK, 8'h00);
		wr(gbx_pkg::IDX_SPI_CTRL, 8'h03);
		@(negedge clk_in);
		chk("ss_int", 32'h1, {31'h0, ss});
		wr(gbx_pkg::IDX_SPI_CTRL, 8'h08);
		aen <= 24'h001000;
		@(negedge clk_in);
		chk("ss_pin", 32'h0, {31'h0, ss});
		chk("mosi_off", 32'h0, {31'h0, poe[gbx_pkg::PIN_MOSI]});
		wr(gbx_pkg::IDX_SPI_CTRL, 8'h00);
		@(negedge clk_in);
		chk("mosi_on", 32'h1, {31'h0, poe[gbx_pkg::PIN_MOSI]});
		@(posedge clk_in);
		aen <= 24'h0;
		$display("test control done");
		wr(gbx_pkg::IDX_A_OPT, 8'h01);
		wr(gbx_pkg::IDX_B_OPT, 8'h01);
		for (int g = 0; g < 2; g++) begin
			for (int m = 0; m < 4; m++) begin
				v = 24'h1 << (g * 8);
				// the other group's source pin stays high so it never fires
				o = 24'h1 << ((1 - g) * 8);
				drv(1'b1, v | o);
				wr(gbx_pkg::IDX_SENSE_CLK, 8'(m << (g ? 6 : 3)));
				drv(1'b0, o);
				e = (m != 1);
				chk("fall", 32'(e) << g, {30'h0, i1, i0});
				chk("wake", 32'(e), {31'h0, wake});
				drv(1'b1, o);
				wr(gbx_pkg::IDX_SENSE_CLK, 8'(m << (g ? 6 : 3)));
				@(negedge clk_in);
				chk("clr_sense", 32'h0, {30'h0, i1, i0});
				// mode 00 pends on the low level before the rise arrives
				drv(1'b0, v | o);
				chk("rise", 32'(m != 2) << g, {30'h0, i1, i0});
				@(posedge clk_in);
				v0 <= (g == 0);
				v1 <= (g == 1);
				@(posedge clk_in);
				v0 <= 1'b0;
				v1 <= 1'b0;
				repeat (2) @(posedge clk_in);
				chk("clr_vec", 32'h0, {30'h0, i1, i0});
			end
		end
		drv(1'b1, 24'h0);
		wr(gbx_pkg::IDX_A_OPT, 8'h03);
		wr(gbx_pkg::IDX_SENSE_CLK, 8'h08);
		drv(1'b0, 24'h1);
		chk("and_low", 32'h0, {31'h0, i0});
		drv(1'b0, 24'h3);
		chk("and_high", 32'h1, {31'h0, i0});
		drv(1'b1, 24'h000103);
		wr(gbx_pkg::IDX_C_OPT, 8'h01);
		wr(gbx_pkg::IDX_SRC_CFG, 8'h01);
		wr(gbx_pkg::IDX_SENSE_CLK, 8'h00);
		drv(1'b0, 24'h000103);
		chk("src_c_grp0", 32'h1, {30'h0, i1, i0});
		drv(1'b1, 24'h000103);
		wr(gbx_pkg::IDX_SRC_CFG, 8'h00);
		wr(gbx_pkg::IDX_SENSE_CLK, 8'h00);
		drv(1'b0, 24'h000103);
		chk("src_c_grp1", 32'h2, {30'h0, i1, i0});
		$display("test interrupts done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
